// ==== src/mdc_map.svh ====
// Register map, field positions and reset values of the demodulator control bank
// Contract
// - Control state machine runs only while control_enable holds 1.
// - control_state reads 00 idle, 01 frame sync, 10 mux frame, 11 frozen.
// - Mask bits 0 to 2 at 0 force their control outputs low.
// - Mask bit 5 at 1 forces averager full-length signal to 1.
// - Mask bit 4 at 0 blocks frozen to mux-frame-locked transition.
// - Mask bit 3 at 0 blocks frozen to frame-sync-locked transition.
// - Both bits 0: frozen left only by disable or init trigger.
// - Init trigger write of 1 reinitializes machine unless already idle.
// - Initialization also restarts frame synchronizer and coarse frequency estimator.
// - Frozen entered after threshold run of consecutive locked mux frames, reset 0x18.
// - Output mean amplitude readable as unsigned 8-bit in 1/256 units.
// - Output clip rate readable as 8-bit fraction in 1/256 units.
// - NCO increment readable as 17-bit two's complement value.
// - Fine frequency part readable as separate 17-bit two's complement value.
// - Failed acquisition detections counted in 12 bits per observation interval.
// - Current weighted peak correlation inside window readable in 7 bits.
// - Position of that peak inside window readable in 11 bits.
// - Max and min correlation readable for inside and outside window.
// - Observation interval is a count of 7.2 ms multicarrier frames.
`ifndef MDC_MAP_SVH
`define MDC_MAP_SVH

`define MDC_A_FAIL_LO     16'h0144
`define MDC_A_FAIL_HI     16'h0145
`define MDC_A_MAX_IN      16'h0147
`define MDC_A_MAX_OUT     16'h0149
`define MDC_A_MIN_IN      16'h014b
`define MDC_A_MIN_OUT     16'h014d
`define MDC_A_PARITY      16'h014f
`define MDC_A_PEAK        16'h0150
`define MDC_A_PEAK_POS_LO 16'h0151
`define MDC_A_PEAK_POS_HI 16'h0152
`define MDC_A_SHIFT_LO    16'h0153
`define MDC_A_SHIFT_HI    16'h0154
`define MDC_A_JUMP_LO     16'h0155
`define MDC_A_JUMP_HI     16'h0156
`define MDC_A_NCO_LO      16'h0160
`define MDC_A_NCO_MID     16'h0161
`define MDC_A_NCO_HI      16'h0162
`define MDC_A_FINE_LO     16'h0170
`define MDC_A_FINE_MID    16'h0171
`define MDC_A_FINE_HI     16'h0172
`define MDC_A_ENABLE      16'h0180
`define MDC_A_MASK        16'h0181
`define MDC_A_INIT        16'h0182
`define MDC_A_THRESH      16'h0183
`define MDC_A_STATE       16'h0184
`define MDC_A_MEAN        16'h0190
`define MDC_A_CLIP        16'h0191

`define MDC_RST_ENABLE    1'h0
`define MDC_RST_MASK      6'h1f
`define MDC_RST_THRESH    8'h18

`define MDC_MB_RESTART    0
`define MDC_MB_HOLD       1
`define MDC_MB_TIMEOUT    2
`define MDC_MB_TO_FS      3
`define MDC_MB_TO_MUX     4
`define MDC_MB_AVG        5

`endif

// ==== src/mdc_pkg.sv ====
// Types shared by the demodulator control bank
package mdc_pkg;
	typedef enum logic [1:0] {
		MDC_IDLE,
		MDC_FS_LOCKED,
		MDC_MUX_LOCKED,
		MDC_FROZEN
	} mdc_state_type;
endpackage

// ==== src/mdc_fail_window.sv ====
// Failed acquisition-sequence counter over a programmable frame interval
`timescale 1ns/1ps
`default_nettype none
module mdc_fail_window #(
	parameter int FAIL_W = 12
)(
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_frame_start,
	input  wire logic              i_fail,
	input  wire logic [11:0]       i_interval_len,
	output logic      [FAIL_W-1:0] o_fail_count
);
	logic [11:0]       frame_cnt_r;
	logic [FAIL_W-1:0] fail_cnt_r;
	logic [FAIL_W-1:0] fail_inc;
	logic              interval_end;

	// Saturate rather than wrap so a bad interval never reads as a good one
	assign fail_inc = (i_fail && !(&fail_cnt_r)) ? fail_cnt_r + FAIL_W'(1) : fail_cnt_r;
	// A length of 0 behaves as 1 frame
	assign interval_end = i_frame_start && (13'(frame_cnt_r) + 13'd1 >= 13'(i_interval_len));

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			frame_cnt_r <= 12'h000;
		else if (interval_end)
			frame_cnt_r <= 12'h000;
		else if (i_frame_start)
			frame_cnt_r <= frame_cnt_r + 12'h001;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			fail_cnt_r   <= '0;
			o_fail_count <= '0;
		end
		else if (interval_end)
		begin
			o_fail_count <= fail_inc;
			fail_cnt_r   <= '0;
		end
		else
			fail_cnt_r <= fail_inc;
	end
endmodule
`default_nettype wire

// ==== src/mdc_ctrl_status.sv ====
// Demodulator control state machine and its byte-wide register bank
`timescale 1ns/1ps
`default_nettype none
`include "mdc_map.svh"
module mdc_ctrl_status
	import mdc_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic [15:0] i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	input  wire logic        i_fs_locked,
	input  wire logic        i_tdm_frame,
	input  wire logic        i_tdm_locked,
	input  wire logic        i_mc_frame_start,
	input  wire logic        i_amss_fail,
	input  wire logic [11:0] i_interval_len,
	input  wire logic        i_corr_valid,
	input  wire logic        i_corr_inside,
	input  wire logic [6:0]  i_corr_value,
	input  wire logic [10:0] i_corr_pos,
	input  wire logic [11:0] i_history_shift,
	input  wire logic [10:0] i_window_jump,
	input  wire logic [16:0] i_nco_step,
	input  wire logic [16:0] i_fine_freq,
	input  wire logic [7:0]  i_mean_amp,
	input  wire logic [7:0]  i_clip_rate,
	input  wire logic        i_avg_full_len,
	output logic             o_sync_restart_output_gate,
	output logic             o_freq_hold_output_gate,
	output logic             o_timeout_disable_gate,
	output logic             o_avg_full_len,
	output logic             o_frame_sync_init,
	output logic             o_coarse_freq_init,
	output logic      [1:0]  o_control_state
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	mdc_state_type state_r;
	mdc_state_type state_nxt;
	logic          enable_r;
	logic [5:0]    mask_r;
	logic [7:0]    thresh_r;
	logic [7:0]    lock_cnt_r;
	logic          lock_reach;
	logic          init_req;
	logic          parity_r;
	logic [6:0]    peak_r;
	logic [10:0]   peak_pos_r;
	logic [11:0]   shift_r;
	logic [10:0]   jump_r;
	logic [16:0]   nco_r;
	logic [16:0]   fine_r;
	logic [7:0]    mean_r;
	logic [7:0]    clip_r;
	logic [11:0]   fail_count;
	logic [7:0]    rd_nxt;

	function automatic logic [7:0] mdc_pick(input logic [23:0] v, input logic [1:0] idx);
		mdc_pick = v[{idx, 3'b000} +: 8];
	endfunction

	function automatic logic wr_hit(input logic [15:0] a);
		wr_hit = i_reg_wr && (i_reg_addr == a);
	endfunction

	// Init acts on the write itself; the trigger byte is not stored and reads 0
	assign init_req = wr_hit(`MDC_A_INIT) && i_reg_wdata[0];

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			enable_r <= `MDC_RST_ENABLE;
			mask_r   <= `MDC_RST_MASK;
			thresh_r <= `MDC_RST_THRESH;
		end
		else
		begin
			if (wr_hit(`MDC_A_ENABLE))
				enable_r <= i_reg_wdata[0];
			if (wr_hit(`MDC_A_MASK))
				mask_r <= i_reg_wdata[5:0];
			if (wr_hit(`MDC_A_THRESH))
				thresh_r <= i_reg_wdata;
		end
	end

	// Run counted from the first locked frame after reaching mux-frame lock
	assign lock_reach = (9'(lock_cnt_r) + 9'd1) >= 9'(thresh_r);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			MDC_IDLE:
				if (i_fs_locked)
					state_nxt = MDC_FS_LOCKED;
			MDC_FS_LOCKED:
				if (!i_fs_locked)
					state_nxt = MDC_IDLE;
				else if (i_tdm_frame && i_tdm_locked)
					state_nxt = MDC_MUX_LOCKED;
			MDC_MUX_LOCKED:
				if (!i_fs_locked)
					state_nxt = MDC_IDLE;
				else if (i_tdm_frame && !i_tdm_locked)
					state_nxt = MDC_FS_LOCKED;
				else if (i_tdm_frame && lock_reach)
					state_nxt = MDC_FROZEN;
			MDC_FROZEN:
				if (mask_r[`MDC_MB_TO_FS] && !i_fs_locked)
					state_nxt = MDC_FS_LOCKED;
				else if (mask_r[`MDC_MB_TO_MUX] && i_tdm_frame && !i_tdm_locked)
					state_nxt = MDC_MUX_LOCKED;
		endcase
		// Disable and init override every transition, including a held frozen state
		if (!enable_r || init_req)
			state_nxt = MDC_IDLE;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_r <= MDC_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			lock_cnt_r <= 8'h00;
		else if (state_nxt != MDC_MUX_LOCKED || state_r != MDC_MUX_LOCKED)
			lock_cnt_r <= 8'h00;
		else if (i_tdm_frame && i_tdm_locked && !(&lock_cnt_r))
			lock_cnt_r <= lock_cnt_r + 8'h01;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_frame_sync_init  <= 1'b0;
			o_coarse_freq_init <= 1'b0;
		end
		else
		begin
			o_frame_sync_init  <= init_req && state_r != MDC_IDLE;
			o_coarse_freq_init <= init_req && state_r != MDC_IDLE;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sync_restart_output_gate <= 1'b0;
			o_freq_hold_output_gate    <= 1'b0;
			o_timeout_disable_gate     <= 1'b0;
			o_avg_full_len             <= 1'b0;
			o_control_state            <= 2'h0;
		end
		else
		begin
			o_sync_restart_output_gate <= enable_r && state_r == MDC_IDLE
				&& mask_r[`MDC_MB_RESTART];
			o_freq_hold_output_gate    <= state_r == MDC_FROZEN && mask_r[`MDC_MB_HOLD];
			o_timeout_disable_gate     <= state_r != MDC_IDLE && mask_r[`MDC_MB_TIMEOUT];
			o_avg_full_len             <= i_avg_full_len || mask_r[`MDC_MB_AVG];
			o_control_state            <= 2'(state_r);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			parity_r <= 1'b0;
		else if (i_mc_frame_start)
			parity_r <= !parity_r;
	end

	// Live observations; a multi-byte read is not atomic across its bytes
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			shift_r <= 12'h000;
			jump_r  <= 11'h000;
			nco_r   <= 17'h00000;
			fine_r  <= 17'h00000;
			mean_r  <= 8'h00;
			clip_r  <= 8'h00;
		end
		else
		begin
			shift_r <= i_history_shift;
			jump_r  <= i_window_jump;
			nco_r   <= i_nco_step;
			fine_r  <= i_fine_freq;
			mean_r  <= i_mean_amp;
			clip_r  <= i_clip_rate;
		end
	end

	// Peak inside the window restarts at each frame boundary
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			peak_r     <= 7'h00;
			peak_pos_r <= 11'h000;
		end
		else if (i_corr_valid && i_corr_inside && (i_mc_frame_start || i_corr_value > peak_r))
		begin
			peak_r     <= i_corr_value;
			peak_pos_r <= i_corr_pos;
		end
		else if (i_mc_frame_start)
			peak_r <= 7'h00;
	end

	// Index 0 tracks inside the window, index 1 outside; latched per frame
	for (genvar g = 0; g < 2; g++)
	begin : g_win
		logic       hit;
		logic [6:0] run_max_r;
		logic [6:0] run_min_r;
		logic [6:0] rd_max_r;
		logic [6:0] rd_min_r;

		assign hit = i_corr_valid && (i_corr_inside == (g == 0));

		always_ff @(posedge i_sys_clk or negedge i_rst_n)
		begin
			if (!i_rst_n)
			begin
				run_max_r <= 7'h00;
				run_min_r <= 7'h7f;
				rd_max_r  <= 7'h00;
				rd_min_r  <= 7'h00;
			end
			else if (i_mc_frame_start)
			begin
				rd_max_r  <= run_max_r;
				rd_min_r  <= run_min_r;
				run_max_r <= hit ? i_corr_value : 7'h00;
				run_min_r <= hit ? i_corr_value : 7'h7f;
			end
			else if (hit)
			begin
				if (i_corr_value > run_max_r)
					run_max_r <= i_corr_value;
				if (i_corr_value < run_min_r)
					run_min_r <= i_corr_value;
			end
		end
	end

	mdc_fail_window #(
		.FAIL_W (12)
	) i_mdc_fail_window (
		.i_sys_clk      (i_sys_clk),
		.i_rst_n        (i_rst_n),
		.i_frame_start  (i_mc_frame_start),
		.i_fail         (i_amss_fail),
		.i_interval_len (i_interval_len),
		.o_fail_count   (fail_count)
	);

	always_comb
	begin
		rd_nxt = 8'h00;
		unique case (i_reg_addr)
			`MDC_A_FAIL_LO:     rd_nxt = mdc_pick(24'(fail_count), 2'd0);
			`MDC_A_FAIL_HI:     rd_nxt = mdc_pick(24'(fail_count), 2'd1);
			`MDC_A_MAX_IN:      rd_nxt = {1'b0, g_win[0].rd_max_r};
			`MDC_A_MAX_OUT:     rd_nxt = {1'b0, g_win[1].rd_max_r};
			`MDC_A_MIN_IN:      rd_nxt = {1'b0, g_win[0].rd_min_r};
			`MDC_A_MIN_OUT:     rd_nxt = {1'b0, g_win[1].rd_min_r};
			`MDC_A_PARITY:      rd_nxt = {7'h00, parity_r};
			`MDC_A_PEAK:        rd_nxt = {1'b0, peak_r};
			`MDC_A_PEAK_POS_LO: rd_nxt = mdc_pick(24'(peak_pos_r), 2'd0);
			`MDC_A_PEAK_POS_HI: rd_nxt = mdc_pick(24'(peak_pos_r), 2'd1);
			`MDC_A_SHIFT_LO:    rd_nxt = mdc_pick(24'(shift_r), 2'd0);
			`MDC_A_SHIFT_HI:    rd_nxt = mdc_pick(24'(shift_r), 2'd1);
			`MDC_A_JUMP_LO:     rd_nxt = mdc_pick(24'(jump_r), 2'd0);
			`MDC_A_JUMP_HI:     rd_nxt = mdc_pick(24'(jump_r), 2'd1);
			`MDC_A_NCO_LO:      rd_nxt = mdc_pick(24'(nco_r), 2'd0);
			`MDC_A_NCO_MID:     rd_nxt = mdc_pick(24'(nco_r), 2'd1);
			`MDC_A_NCO_HI:      rd_nxt = mdc_pick(24'(nco_r), 2'd2);
			`MDC_A_FINE_LO:     rd_nxt = mdc_pick(24'(fine_r), 2'd0);
			`MDC_A_FINE_MID:    rd_nxt = mdc_pick(24'(fine_r), 2'd1);
			`MDC_A_FINE_HI:     rd_nxt = mdc_pick(24'(fine_r), 2'd2);
			`MDC_A_ENABLE:      rd_nxt = {7'h00, enable_r};
			`MDC_A_MASK:        rd_nxt = {2'h0, mask_r};
			`MDC_A_THRESH:      rd_nxt = thresh_r;
			`MDC_A_STATE:       rd_nxt = {6'h00, 2'(state_r)};
			`MDC_A_MEAN:        rd_nxt = mean_r;
			`MDC_A_CLIP:        rd_nxt = clip_r;
			default:            rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			o_reg_rdata <= rd_nxt;
	end

	AST_DISABLE_IDLE: assert property (!enable_r |=> state_r == MDC_IDLE ##1 o_control_state == 2'h0)
		else $error("disabled machine left idle");
	AST_FROZEN_CODE: assert property (state_r == MDC_FROZEN |=> o_control_state == 2'h3)
		else $error("frozen state reads wrong code");
	AST_MASK_RESTART: assert property (!mask_r[0] |=> !o_sync_restart_output_gate)
		else $error("masked restart gate high");
	AST_MASK_HOLD: assert property (!mask_r[1] |=> !o_freq_hold_output_gate)
		else $error("masked hold gate high");
	AST_MASK_TIMEOUT: assert property (!mask_r[2] |=> !o_timeout_disable_gate)
		else $error("masked timeout gate high");
	AST_AVG_FORCE: assert property (mask_r[5] |=> o_avg_full_len)
		else $error("averager length not forced");
	AST_NO_MUX_RETURN: assert property (state_r == MDC_FROZEN && !mask_r[4]
		|=> state_r != MDC_MUX_LOCKED)
		else $error("blocked frozen to mux transition taken");
	AST_NO_FS_RETURN: assert property (state_r == MDC_FROZEN && !mask_r[3]
		|=> state_r != MDC_FS_LOCKED)
		else $error("blocked frozen to frame sync transition taken");
	AST_FROZEN_HOLD: assert property (state_r == MDC_FROZEN && mask_r[4:3] == 2'b00
		&& enable_r && !init_req |=> state_r == MDC_FROZEN)
		else $error("frozen state left without disable or init");
	AST_INIT_ACTS: assert property (init_req && state_r != MDC_IDLE
		|=> state_r == MDC_IDLE && o_frame_sync_init && o_coarse_freq_init)
		else $error("init trigger ignored");
	AST_INIT_NOP: assert property (init_req && state_r == MDC_IDLE |=> !o_frame_sync_init)
		else $error("init from idle restarted synchronizer");
	AST_FROZEN_ENTRY: assert property (state_r == MDC_MUX_LOCKED ##1 state_r == MDC_FROZEN
		|-> $past(lock_reach) && $past(i_tdm_frame))
		else $error("frozen entered before lock run");
	AST_PARITY: assert property (i_mc_frame_start |=> parity_r != $past(parity_r))
		else $error("parity flag did not invert");
	AST_RD_STATE: assert property (i_reg_rd && i_reg_addr == `MDC_A_STATE
		|=> o_reg_rdata == {6'h00, 2'($past(state_r))})
		else $error("state readback wrong");

	COV_FROZEN: cover property (state_r == MDC_MUX_LOCKED ##1 state_r == MDC_FROZEN);
	COV_INIT: cover property (init_req && state_r == MDC_FROZEN);
	COV_FROZEN_EXIT: cover property (state_r == MDC_FROZEN ##1 state_r == MDC_MUX_LOCKED);
	COV_PARITY: cover property (i_mc_frame_start ##1 parity_r);
endmodule
`default_nettype wire

// ==== verification/mdc_ctrl_status_test.sv ====
// Self-checking bench for the demodulator control register bank
`timescale 1ns/1ps
`default_nettype none
`include "mdc_map.svh"
module mdc_ctrl_status_test
	import mdc_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [15:0] addr;
	logic        wr;
	logic        rd;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        fs_lk;
	logic        tdm_f;
	logic        tdm_lk;
	logic        mcf;
	logic        fail;
	logic [11:0] ilen;
	logic        cv;
	logic        cin;
	logic [6:0]  cval;
	logic [10:0] cpos;
	logic [11:0] hsh;
	logic [10:0] jmp;
	logic [16:0] nco;
	logic [16:0] ffq;
	logic [7:0]  mean;
	logic [7:0]  clip;
	logic        avg_in;
	logic        g_rst;
	logic        g_hold;
	logic        g_to;
	logic        avg_o;
	logic        sync_restart_output_gate;
	logic        cf_init;
	logic [1:0]  st;
	logic [1:0]  st_q;
	int          miscompares;
	int          compares;
	int          n_fs;
	int          n_cf;
	int          n_31;

	mdc_ctrl_status i_mdc_ctrl_status (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_fs_locked(fs_lk),
		.i_tdm_frame(tdm_f), .i_tdm_locked(tdm_lk), .i_mc_frame_start(mcf),
		.i_amss_fail(fail), .i_interval_len(ilen), .i_corr_valid(cv), .i_corr_inside(cin),
		.i_corr_value(cval), .i_corr_pos(cpos), .i_history_shift(hsh),
		.i_window_jump(jmp), .i_nco_step(nco), .i_fine_freq(ffq), .i_mean_amp(mean),
		.i_clip_rate(clip), .i_avg_full_len(avg_in),
		.o_sync_restart_output_gate(g_rst), .o_freq_hold_output_gate(g_hold),
		.o_timeout_disable_gate(g_to), .o_avg_full_len(avg_o),
		.o_frame_sync_init(sync_restart_output_gate), .o_coarse_freq_init(cf_init), .o_control_state(st)
	);

	always #25 clk = ~clk;

	// Transient states last one cycle, so they are caught here rather than by polling
	always @(posedge clk)
	begin
		st_q <= st;
		if (sync_restart_output_gate === 1'b1)
			n_fs++;
		if (cf_init === 1'b1)
			n_cf++;
		if (st_q === 2'h3 && st === 2'h1)
			n_31++;
	end

	task automatic end_sim;
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [16:0] s, input logic [16:0] e);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_get(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] v;
		reg_get(a, v);
		chk({9'h0, v}, {9'h0, e});
	endtask

	task automatic tdm(input logic lk);
		@(posedge clk);
		tdm_f <= 1'b1;
		tdm_lk <= lk;
		@(posedge clk);
		tdm_f <= 1'b0;
	endtask

	task automatic frame;
		@(posedge clk);
		mcf <= 1'b1;
		@(posedge clk);
		mcf <= 1'b0;
	endtask

	task automatic samp(input logic ins, input logic [6:0] v, input logic [10:0] p);
		@(posedge clk);
		cv <= 1'b1;
		cin <= ins;
		cval <= v;
		cpos <= p;
		@(posedge clk);
		cv <= 1'b0;
	endtask

	task automatic wait_st(input logic [1:0] e);
		int k;
		k = 0;
		#1;
		while (st !== e && k < 12)
		begin
			idle(1);
			k++;
		end
		chk({15'h0, st}, {15'h0, e});
	endtask

	task automatic t_reset;
		reg_rd(`MDC_A_ENABLE, 8'h00);
		reg_rd(`MDC_A_MASK, 8'h1f);
		reg_rd(`MDC_A_INIT, 8'h00);
		reg_rd(`MDC_A_THRESH, 8'h18);
		reg_rd(`MDC_A_STATE, 8'h00);
		reg_wr(`MDC_A_STATE, 8'hff);
		reg_rd(`MDC_A_STATE, 8'h00);
		reg_rd(16'h0100, 8'h00);
		chk({16'h0, g_rst}, 17'h0);
	endtask

	task automatic t_live;
		@(posedge clk);
		nco <= 17'h1a5c3;
		ffq <= 17'h05a3c;
		hsh <= 12'habc;
		jmp <= 11'h5a5;
		mean <= 8'hff;
		clip <= 8'h80;
		reg_rd(`MDC_A_NCO_LO, 8'hc3);
		reg_rd(`MDC_A_NCO_MID, 8'ha5);
		reg_rd(`MDC_A_NCO_HI, 8'h01);
		reg_rd(`MDC_A_FINE_LO, 8'h3c);
		reg_rd(`MDC_A_FINE_MID, 8'h5a);
		reg_rd(`MDC_A_FINE_HI, 8'h00);
		reg_rd(`MDC_A_SHIFT_LO, 8'hbc);
		reg_rd(`MDC_A_SHIFT_HI, 8'h0a);
		reg_rd(`MDC_A_JUMP_LO, 8'ha5);
		reg_rd(`MDC_A_JUMP_HI, 8'h05);
		reg_rd(`MDC_A_MEAN, 8'hff);
		reg_rd(`MDC_A_CLIP, 8'h80);
	endtask

	task automatic t_corr;
		logic [7:0] p;
		frame();
		samp(1'b1, 7'h30, 11'h100);
		samp(1'b1, 7'h50, 11'h4c8);
		samp(1'b1, 7'h40, 11'h300);
		samp(1'b0, 7'h10, 11'h050);
		samp(1'b0, 7'h70, 11'h060);
		reg_rd(`MDC_A_PEAK, 8'h50);
		reg_rd(`MDC_A_PEAK_POS_LO, 8'hc8);
		reg_rd(`MDC_A_PEAK_POS_HI, 8'h04);
		reg_get(`MDC_A_PARITY, p);
		frame();
		reg_rd(`MDC_A_MAX_IN, 8'h50);
		reg_rd(`MDC_A_MIN_IN, 8'h30);
		reg_rd(`MDC_A_MAX_OUT, 8'h70);
		reg_rd(`MDC_A_MIN_OUT, 8'h10);
		reg_rd(`MDC_A_PARITY, {7'h0, ~p[0]});
	endtask

	task automatic t_fail;
		@(posedge clk);
		ilen <= 12'h001;
		frame();
		repeat (3)
		begin
			@(posedge clk);
			fail <= 1'b1;
			@(posedge clk);
			fail <= 1'b0;
		end
		frame();
		reg_rd(`MDC_A_FAIL_LO, 8'h03);
		reg_rd(`MDC_A_FAIL_HI, 8'h00);
		// Two frames per interval: the first boundary must not publish the count
		@(posedge clk);
		ilen <= 12'h002;
		fail <= 1'b1;
		@(posedge clk);
		fail <= 1'b0;
		frame();
		reg_rd(`MDC_A_FAIL_LO, 8'h03);
		@(posedge clk);
		fail <= 1'b1;
		@(posedge clk);
		fail <= 1'b0;
		frame();
		reg_rd(`MDC_A_FAIL_LO, 8'h02);
	endtask

	task automatic t_state;
		reg_wr(`MDC_A_THRESH, 8'h02);
		reg_wr(`MDC_A_ENABLE, 8'h01);
		idle(3);
		chk({16'h0, g_rst}, 17'h1);
		@(posedge clk) fs_lk <= 1'b1;
		wait_st(2'h1);
		tdm(1'b1);
		wait_st(2'h2);
		tdm(1'b1);
		idle(3);
		chk({15'h0, st}, 17'h2);
		tdm(1'b1);
		wait_st(2'h3);
		idle(2);
		chk({15'h0, g_hold, g_to}, 17'h3);
		tdm(1'b0);
		wait_st(2'h2);
		tdm(1'b1);
		tdm(1'b1);
		wait_st(2'h3);
		@(posedge clk) fs_lk <= 1'b0;
		wait_st(2'h0);
		chk(17'(n_31), 17'h1);
	endtask

	task automatic t_freeze;
		int a;
		int b;
		reg_wr(`MDC_A_MASK, 8'h05);
		@(posedge clk) fs_lk <= 1'b1;
		wait_st(2'h1);
		tdm(1'b1);
		tdm(1'b1);
		tdm(1'b1);
		wait_st(2'h3);
		idle(2);
		chk({15'h0, g_hold, g_to}, 17'h1);
		@(posedge clk) fs_lk <= 1'b0;
		tdm(1'b0);
		idle(6);
		chk({15'h0, st}, 17'h3);
		a = n_fs;
		b = n_cf;
		reg_wr(`MDC_A_INIT, 8'h01);
		wait_st(2'h0);
		idle(2);
		chk(17'(n_fs), 17'(a + 1));
		chk(17'(n_cf), 17'(b + 1));
		reg_rd(`MDC_A_INIT, 8'h00);
		// A second trigger while idle must leave the frame sync restart untouched
		reg_wr(`MDC_A_INIT, 8'h01);
		idle(4);
		chk(17'(n_fs), 17'(a + 1));
		chk({16'h0, g_rst}, 17'h1);
		reg_wr(`MDC_A_MASK, 8'h04);
		idle(3);
		chk({16'h0, g_rst}, 17'h0);
		reg_wr(`MDC_A_MASK, 8'h1f);
		@(posedge clk) fs_lk <= 1'b1;
		wait_st(2'h1);
		reg_wr(`MDC_A_ENABLE, 8'h00);
		wait_st(2'h0);
		idle(6);
		chk({15'h0, st}, 17'h0);
		@(posedge clk) fs_lk <= 1'b0;
	endtask

	task automatic t_avg;
		@(posedge clk) avg_in <= 1'b1;
		idle(3);
		chk({16'h0, avg_o}, 17'h1);
		@(posedge clk) avg_in <= 1'b0;
		idle(3);
		chk({16'h0, avg_o}, 17'h0);
		reg_wr(`MDC_A_MASK, 8'h20);
		idle(3);
		chk({16'h0, avg_o}, 17'h1);
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		addr = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
		fs_lk = 1'b0;
		tdm_f = 1'b0;
		tdm_lk = 1'b0;
		mcf = 1'b0;
		fail = 1'b0;
		ilen = 12'h001;
		cv = 1'b0;
		cin = 1'b0;
		cval = 7'h00;
		cpos = 11'h000;
		hsh = 12'h000;
		jmp = 11'h000;
		nco = 17'h00000;
		ffq = 17'h00000;
		mean = 8'h00;
		clip = 8'h00;
		avg_in = 1'b0;
		miscompares = 0;
		compares = 0;
		n_fs = 0;
		n_cf = 0;
		n_31 = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_live();
		t_corr();
		t_fail();
		t_state();
		t_freeze();
		t_avg();
		end_sim();
	end

	// The whole sequence needs well under a thousand cycles; this bound cuts a hang
	initial
	begin
		#(50 * 5000);
		miscompares++;
		end_sim();
	end
endmodule
`default_nettype wire
